// File: vic_pkg.sv
package vic_pkg;
   // ----------------------------------------
   // Vector table layout (program memory word addresses)
   // ----------------------------------------
   localparam int ADDR_W = 24;
   localparam logic [23:0] RESET_ADDR = 24'h000000;
   localparam logic [23:0] PRIMARY_TABLE_BASE = 24'h000004;
   localparam logic [23:0] ALT_TABLE_BASE = 24'h000104;
   localparam logic [23:0] CODE_START = 24'h000200;
   localparam int TRAP_COUNT = 8;
   localparam int SOURCE_COUNT = 118;
   localparam int VECTOR_COUNT = 126;
   localparam int TRAP_OSC_FAIL = 1;
   localparam int TRAP_ADDR_ERR = 2;
   localparam int TRAP_STACK_ERR = 3;
   localparam int TRAP_MATH_ERR = 4;
   localparam int PRIO_W = 3;
   localparam logic [2:0] PRIO_MAX = 3'h7;
   localparam int TRAP_LEVEL = 8;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int REG_ADDR_W = 8;
   localparam logic [7:0] OFF_CONTROL_TWO = 8'h00;
   localparam logic [7:0] OFF_TRAP_STATUS = 8'h01;
   localparam logic [7:0] OFF_CPU_LEVEL = 8'h02;
   localparam logic [7:0] OFF_VECTOR_STATUS = 8'h03;
   localparam logic [7:0] OFF_FLAG_BASE = 8'h10;
   localparam logic [7:0] OFF_ENABLE_BASE = 8'h20;
   localparam logic [7:0] OFF_PRIO_BASE = 8'h30;
   localparam int BANK_WORDS = 8;
   localparam int PRIO_WORDS = 30;
   localparam int ALT_SELECT_BIT = 15;
   localparam int SRC_PER_PRIO_WORD = 4;
   localparam int ENTRY_LATENCY = 2;

   typedef enum logic [1:0] {IDLE_S, FETCH_S, ENTRY_S} svc_state_t;
endpackage

// File: vectored_interrupt_controller.sv
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module vectored_interrupt_controller
   import vic_pkg::*;
#(
   parameter int NUM_SOURCES = SOURCE_COUNT
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [REG_ADDR_W-1:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdData,
   input wire logic [NUM_SOURCES-1:0] sourceEvent,
   input wire logic [4:1] trapEvent,
   input wire logic [2:0] cpuPriorityLevel,
   input wire logic cpuAck,
   input wire logic cpuReturn,
   output logic cpuRequest,
   output logic [ADDR_W-1:0] vectorAddr,
   output logic vectorValid,
   output logic [3:0] serviceLevel,
   output logic [ADDR_W-1:0] resetVector,
   output logic [ADDR_W-1:0] codeStart
);
   localparam int VEC_W = 7;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Word entries are two addresses apart
   function automatic logic [ADDR_W-1:0] fetch_addr(input logic alt, input logic [VEC_W-1:0] vec);
      logic [ADDR_W-1:0] base;
      base = alt ? ALT_TABLE_BASE : PRIMARY_TABLE_BASE;
      return base + {{(ADDR_W-VEC_W-1){1'b0}}, vec, 1'b0};
   endfunction

   function automatic logic [15:0] word_of(input logic [BANK_WORDS*16-1:0] bank,
                                           input logic [REG_ADDR_W-1:0] idx);
      word_of = 16'h0000;
      for (int i = 0; i < BANK_WORDS; i++) begin
         if (idx == REG_ADDR_W'(i)) begin
            word_of = bank[i*16 +: 16];
         end
      end
   endfunction

   // One decoder serves both ports, so the read and write maps cannot drift apart
   function automatic logic in_window(input logic [REG_ADDR_W-1:0] addr,
                                      input logic [REG_ADDR_W-1:0] base,
                                      input int words);
      return (addr >= base) && (addr < base + REG_ADDR_W'(words));
   endfunction

   // Four 3-bit fields per word, one nibble apart
   function automatic logic [PRIO_W-1:0] level_of(input logic [PRIO_WORDS*16-1:0] bank,
                                                  input int s);
      return bank[(s/SRC_PER_PRIO_WORD)*16 + (s%SRC_PER_PRIO_WORD)*4 +: PRIO_W];
   endfunction

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic altTableSelect;
   logic [3:0] trapFlags;
   logic [BANK_WORDS*16-1:0] requestFlagBank;
   logic [BANK_WORDS*16-1:0] sourceEnableBank;
   logic [PRIO_WORDS*16-1:0] sourcePriorityBank;
   svc_state_t state;
   logic [VEC_W-1:0] activeVector;
   logic [1:0] latencyCount;

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   wire logic wrControl = regWr && (regAddr == OFF_CONTROL_TWO);
   wire logic wrTrapStatus = regWr && (regAddr == OFF_TRAP_STATUS);
   wire logic wrFlag = regWr && in_window(regAddr, OFF_FLAG_BASE, BANK_WORDS);
   wire logic wrEnable = regWr && in_window(regAddr, OFF_ENABLE_BASE, BANK_WORDS);
   wire logic wrPrio = regWr && in_window(regAddr, OFF_PRIO_BASE, PRIO_WORDS);
   wire logic [REG_ADDR_W-1:0] flagIdx = regAddr - OFF_FLAG_BASE;
   wire logic [REG_ADDR_W-1:0] enIdx = regAddr - OFF_ENABLE_BASE;
   wire logic [REG_ADDR_W-1:0] prIdx = regAddr - OFF_PRIO_BASE;

   // ----------------------------------------
   // Control and trap flags
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         altTableSelect <= 1'b0;
      end else if (wrControl) begin
         altTableSelect <= regWrData[ALT_SELECT_BIT];
      end
   end

   // Software clears a flag by writing zero; a same-cycle event wins
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trapFlags <= 4'h0;
      end else begin
         for (int t = 0; t < 4; t++) begin
            if (trapEvent[t+1]) begin
               trapFlags[t] <= 1'b1;
            end else if (wrTrapStatus && !regWrData[t+1]) begin
               trapFlags[t] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // Source request banks
   // ----------------------------------------

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         requestFlagBank <= '0;
      end else begin
         for (int s = 0; s < BANK_WORDS*16; s++) begin
            if (s < NUM_SOURCES && sourceEvent[s < NUM_SOURCES ? s : 0]) begin
               requestFlagBank[s] <= 1'b1;
            end else if (s >= NUM_SOURCES) begin
               requestFlagBank[s] <= 1'b0;
            end else if (wrFlag && flagIdx == REG_ADDR_W'(s/16)) begin
               requestFlagBank[s] <= regWrData[s%16];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sourceEnableBank <= '0;
      end else if (wrEnable) begin
         sourceEnableBank[enIdx[2:0]*16 +: 16] <= regWrData;
      end
   end

   // Each priority word holds four 3-bit fields at nibble spacing
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sourcePriorityBank <= '0;
      end else if (wrPrio) begin
         sourcePriorityBank[prIdx[4:0]*16 +: 16] <= regWrData & 16'h7777;
      end
   end

   // ----------------------------------------
   // Trap arbitration
   // ----------------------------------------
   // Descending scan leaves the oscillator trap as the winner when several stand
   logic anyTrap;
   logic [VEC_W-1:0] trapVec;
   logic anySrc;
   logic [VEC_W-1:0] bestVec;
   logic [2:0] bestLevel;

   always_comb begin
      anyTrap = 1'b0;
      trapVec = '0;
      for (int t = 3; t >= 0; t--) begin
         if (trapFlags[t]) begin
            anyTrap = 1'b1;
            trapVec = VEC_W'(t + TRAP_OSC_FAIL);
         end
      end
   end

   // ----------------------------------------
   // Source arbitration
   // ----------------------------------------
   // Strict greater-than keeps natural order among equal levels
   always_comb begin
      logic [2:0] lvl;
      lvl = 3'h0;
      anySrc = 1'b0;
      bestVec = '0;
      bestLevel = 3'h0;
      for (int s = 0; s < NUM_SOURCES; s++) begin
         lvl = level_of(sourcePriorityBank, s);
         if (requestFlagBank[s] && sourceEnableBank[s]
             && lvl > cpuPriorityLevel && cpuPriorityLevel != PRIO_MAX
             && (!anySrc || lvl > bestLevel)) begin
            anySrc = 1'b1;
            bestVec = VEC_W'(s + TRAP_COUNT);
            bestLevel = lvl;
         end
      end
   end

   // ----------------------------------------
   // Service sequence
   // ----------------------------------------
   wire logic pending = anyTrap || anySrc;
   wire logic entryDone = (latencyCount == 2'h0);

   // A fixed countdown makes entry latency independent of the winner
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= IDLE_S;
      end else begin
         case (state)
            IDLE_S: begin
               if (pending) begin
                  state <= FETCH_S;
               end
            end
            FETCH_S: begin
               if (cpuAck) begin
                  state <= ENTRY_S;
               end
            end
            ENTRY_S: begin
               if (entryDone && cpuReturn) begin
                  state <= IDLE_S;
               end
            end
            default: begin
               state <= IDLE_S;
            end
         endcase
      end
   end

   // Winner is frozen when the request goes out, so a later arrival waits its turn
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         activeVector <= '0;
         serviceLevel <= 4'h0;
      end else if (state == IDLE_S && pending) begin
         activeVector <= anyTrap ? trapVec : bestVec;
         serviceLevel <= anyTrap ? 4'(TRAP_LEVEL) : {1'b0, bestLevel};
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         vectorAddr <= '0;
      end else if (state == FETCH_S && cpuAck) begin
         vectorAddr <= fetch_addr(altTableSelect, activeVector);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         latencyCount <= 2'h0;
      end else if (state == FETCH_S && cpuAck) begin
         latencyCount <= 2'(ENTRY_LATENCY - 1);
      end else if (state == ENTRY_S && !entryDone) begin
         latencyCount <= latencyCount - 2'h1;
      end
   end

   assign cpuRequest = (state == FETCH_S);
   assign vectorValid = (state == ENTRY_S) && entryDone;

   // ----------------------------------------
   // Fixed outputs
   // ----------------------------------------
   // Loaded by reset and held; every output but cpuRequest and vectorValid leaves the block from a flop
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         resetVector <= RESET_ADDR;
         codeStart <= CODE_START;
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         regRdData <= 16'h0000;
      end else if (regRd) begin
         if (regAddr == OFF_CONTROL_TWO) begin
            regRdData <= {altTableSelect, 15'h0000};
         end else if (regAddr == OFF_TRAP_STATUS) begin
            regRdData <= {11'h000, trapFlags, 1'b0};
         end else if (regAddr == OFF_CPU_LEVEL) begin
            regRdData <= {13'h0000, cpuPriorityLevel};
         end else if (regAddr == OFF_VECTOR_STATUS) begin
            regRdData <= {state != IDLE_S, 8'h00, activeVector};
         end else if (in_window(regAddr, OFF_FLAG_BASE, BANK_WORDS)) begin
            regRdData <= word_of(requestFlagBank, flagIdx);
         end else if (in_window(regAddr, OFF_ENABLE_BASE, BANK_WORDS)) begin
            regRdData <= word_of(sourceEnableBank, enIdx);
         end else if (in_window(regAddr, OFF_PRIO_BASE, PRIO_WORDS)) begin
            regRdData <= sourcePriorityBank[prIdx[4:0]*16 +: 16];
         end else begin
            regRdData <= 16'h0000;
         end
      end else begin
         regRdData <= 16'h0000;
      end
   end
endmodule

// File: vic_properties.sv
`timescale 1ns/100ps
module vic_properties
   import vic_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cpuAck,
   input wire logic cpuReturn,
   input wire logic cpuRequest,
   input wire logic [ADDR_W-1:0] vectorAddr,
   input wire logic vectorValid,
   input wire logic [3:0] serviceLevel,
   input wire logic [ADDR_W-1:0] resetVector,
   input wire logic [ADDR_W-1:0] codeStart
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_reset_vector; resetVector == 24'h000000; endproperty
   a_reset_vector: assert property (p_reset_vector) else $error("reset vector moved");
   property p_code_start; codeStart == 24'h000200; endproperty
   a_code_start: assert property (p_code_start) else $error("code start moved");
   property p_req_hold; cpuRequest && !cpuAck |=> cpuRequest; endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped early");
   property p_entry_lat; cpuRequest && cpuAck |=> !vectorValid ##1 vectorValid; endproperty
   a_entry_lat: assert property (p_entry_lat) else $error("entry latency wrong");
   property p_one_service; vectorValid |-> !cpuRequest; endproperty
   a_one_service: assert property (p_one_service) else $error("request during service");
   property p_addr_range;
      vectorValid |-> vectorAddr >= 24'h000004 && vectorAddr <= 24'h0001fe && !vectorAddr[0];
   endproperty
   a_addr_range: assert property (p_addr_range) else $error("vector outside tables");
   property p_trap_slot;
      vectorValid && serviceLevel == 4'h8 |-> vectorAddr[7:0] inside {[8'h06:8'h0c]};
   endproperty
   a_trap_slot: assert property (p_trap_slot) else $error("trap vector misplaced");
   property p_user_slot;
      vectorValid && serviceLevel != 4'h8 |-> vectorAddr[7:0] >= 8'h14 && serviceLevel != 4'h0;
   endproperty
   a_user_slot: assert property (p_user_slot) else $error("user vector misplaced");
   property p_hold_vec; vectorValid && !cpuReturn |=> vectorValid && $stable(vectorAddr); endproperty
   a_hold_vec: assert property (p_hold_vec) else $error("vector not held");
endmodule
bind vectored_interrupt_controller vic_properties u_props(.clk(clk), .sys_rst(sys_rst),
   .cpuAck(cpuAck), .cpuReturn(cpuReturn), .cpuRequest(cpuRequest), .vectorAddr(vectorAddr),
   .vectorValid(vectorValid), .serviceLevel(serviceLevel), .resetVector(resetVector),
   .codeStart(codeStart));

// File: cpu_core_model.sv
`timescale 1ns/100ps
module cpu_core_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cpuRequest,
   input wire logic vectorValid,
   input wire logic [3:0] ackDelay,
   output logic cpuAck,
   output logic cpuReturn
);
   logic [3:0] cnt;
   // Return waits seven cycles so software has time to clear the flag
   always_ff @(posedge clk) begin
      cpuAck <= 1'b0;
      cpuReturn <= 1'b0;
      if (sys_rst) begin
         cnt <= 4'h0;
      end else if (cpuRequest && !cpuAck) begin
         if (cnt >= ackDelay) begin
            cpuAck <= 1'b1;
            cnt <= 4'h0;
         end else cnt <= cnt + 4'h1;
      end else if (vectorValid && !cpuReturn) begin
         if (cnt >= 4'h6) begin
            cpuReturn <= 1'b1;
            cnt <= 4'h0;
         end else cnt <= cnt + 4'h1;
      end
   end
endmodule

// File: tb_vectored_interrupt_controller.sv
`timescale 1ns/100ps
module tb_vectored_interrupt_controller
   import vic_pkg::*;
;
   logic clk = 0, sys_rst = 1, regWr = 0, regRd = 0, cpuAck, cpuReturn, cpuRequest, vectorValid;
   logic [7:0] regAddr = '0;
   logic [15:0] regWrData = '0, regRdData;
   logic [117:0] sourceEvent = '0;
   logic [4:1] trapEvent = '0;
   logic [2:0] cpuPriorityLevel = '0;
   logic [3:0] ackDelay = '0, serviceLevel;
   logic [23:0] vectorAddr, resetVector, codeStart;
   int fails = 0, compares = 0;
   always #4 clk = ~clk;
   vectored_interrupt_controller DUT(.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .sourceEvent(sourceEvent), .trapEvent(trapEvent), .cpuPriorityLevel(cpuPriorityLevel),
      .cpuAck(cpuAck), .cpuReturn(cpuReturn), .cpuRequest(cpuRequest), .vectorAddr(vectorAddr),
      .vectorValid(vectorValid), .serviceLevel(serviceLevel), .resetVector(resetVector),
      .codeStart(codeStart));
   cpu_core_model core(.clk(clk), .sys_rst(sys_rst), .cpuRequest(cpuRequest),
      .vectorValid(vectorValid), .ackDelay(ackDelay), .cpuAck(cpuAck), .cpuReturn(cpuReturn));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic summarize();
      if (fails == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a; regWrData <= d; regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      regAddr <= a; regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk("regRdData", {8'h00, e}, {8'h00, regRdData});
   endtask
   task automatic ev(input logic [117:0] m, input logic [4:1] t);
      @(posedge clk);
      sourceEvent <= m; trapEvent <= t;
      @(posedge clk);
      sourceEvent <= '0; trapEvent <= '0;
   endtask
   // Waits for entry, checks the vector, then clears the flag before the core returns
   task automatic service(input logic [23:0] a, input logic [3:0] l, input logic [7:0] fa,
      input logic [15:0] fv);
      int i;
      i = 0;
      while (vectorValid !== 1'b1 && i < 60) begin @(posedge clk); #1; i++; end
      chk("vectorAddr", a, vectorAddr);
      chk("serviceLevel", {20'h0, l}, {20'h0, serviceLevel});
      wr(fa, fv);
      i = 0;
      while (vectorValid === 1'b1 && i < 60) begin @(posedge clk); #1; i++; end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic scen_reset_values();
      chk("resetVector", 24'h000000, resetVector);
      chk("codeStart", 24'h000200, codeStart);
      rd(OFF_CONTROL_TWO, 16'h0000);
      rd(8'hff, 16'h0000);
   endtask
   task automatic scen_table_ends();
      wr(OFF_ENABLE_BASE, 16'h0001);
      wr(OFF_PRIO_BASE, 16'h0001);
      ev(118'h1, 4'h0);
      service(24'h000014, 4'h1, OFF_FLAG_BASE, 16'h0000);
      wr(8'h27, 16'h0020);
      wr(8'h4d, 16'h0020);
      ev(118'h1 << 117, 4'h0);
      service(24'h0000fe, 4'h2, 8'h17, 16'h0000);
   endtask
   task automatic scen_equal_levels();
      wr(OFF_ENABLE_BASE, 16'h0028);
      wr(OFF_PRIO_BASE, 16'h3000);
      wr(8'h31, 16'h0030);
      ev(118'h28, 4'h0);
      service(24'h00001a, 4'h3, OFF_FLAG_BASE, 16'h0020);
      service(24'h00001e, 4'h3, OFF_FLAG_BASE, 16'h0000);
   endtask
   task automatic scen_level_order();
      wr(8'h31, 16'h0050);
      ev(118'h28, 4'h0);
      service(24'h00001e, 4'h5, OFF_FLAG_BASE, 16'h0008);
      service(24'h00001a, 4'h3, OFF_FLAG_BASE, 16'h0000);
   endtask
   task automatic scen_level_seven();
      @(posedge clk);
      cpuPriorityLevel <= 3'h7;
      ev(118'h8, 4'h0);
      repeat (20) @(posedge clk);
      #1 chk("cpuRequest", 24'h0, {23'h0, cpuRequest});
      ev(118'h0, 4'h2);
      service(24'h000008, 4'h8, OFF_TRAP_STATUS, 16'h0000);
      @(posedge clk);
      cpuPriorityLevel <= 3'h0;
      service(24'h00001a, 4'h3, OFF_FLAG_BASE, 16'h0000);
   endtask
   task automatic scen_alternate();
      @(posedge clk);
      ackDelay <= 4'h5;
      wr(OFF_CONTROL_TWO, 16'h8000);
      rd(OFF_CONTROL_TWO, 16'h8000);
      ev(118'h0, 4'h1);
      service(24'h000106, 4'h8, OFF_TRAP_STATUS, 16'h0000);
      ev(118'h1 << 117, 4'h0);
      service(24'h0001fe, 4'h2, 8'h17, 16'h0000);
   endtask
   // Mid-run reset must clear select, enables and flags alike
   task automatic scen_reset_clears();
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(OFF_CONTROL_TWO, 16'h0000);
      rd(8'h27, 16'h0000);
      rd(8'h17, 16'h0000);
      ev(118'h1 << 117, 4'h0);
      rd(8'h17, 16'h0020);
      chk("cpuRequest", 24'h0, {23'h0, cpuRequest});
   endtask
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      scen_reset_values();
      scen_table_ends();
      scen_equal_levels();
      scen_level_order();
      scen_level_seven();
      scen_alternate();
      scen_reset_clears();
      summarize();
   end
   initial begin
      #100000;
      fails++;
      summarize();
   end
endmodule
